// [acr_pkg.sv]
// Shared constants, types and helpers for the amplifier, input select and gain calibration register slice.
// Assumes a single clock domain and byte-wide register access.
package acr_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_GAIN_CAL_LO  = 8'h0a;
    localparam logic [7:0] ADDR_GAIN_CAL_MID = 8'h0b;
    localparam logic [7:0] ADDR_GAIN_CAL_HI  = 8'h0c;
    localparam logic [7:0] ADDR_RSVD_ONES    = 8'h0d;
    localparam logic [7:0] ADDR_RSVD_ZERO_A  = 8'h0e;
    localparam logic [7:0] ADDR_RSVD_ZERO_B  = 8'h0f;
    localparam logic [7:0] ADDR_AMP_CONFIG   = 8'h10;
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'h11;

    // Values after reset
    localparam logic [23:0] GAIN_CAL_RESET    = 24'h400000;
    localparam logic [7:0]  AMP_CONFIG_RESET  = 8'h00;
    localparam logic [7:0]  INPUT_SELECT_RESET = 8'hff;
    localparam logic [7:0]  READ_ZERO         = 8'h00;

    // Field positions
    localparam int AMP_BYPASS_BIT   = 7;
    localparam int INPUT_POS_LSB    = 4;
    localparam int GAIN_CAL_SHIFT   = 22;

    // Gain codes and factors
    localparam logic [2:0] GAIN_CODE_X1   = 3'h0;
    localparam logic [2:0] GAIN_CODE_X64  = 3'h6;
    localparam logic [2:0] GAIN_CODE_X128 = 3'h7;
    localparam logic [7:0] GAIN_X1        = 8'h01;
    localparam logic [7:0] GAIN_X64       = 8'h40;
    localparam logic [7:0] GAIN_X128      = 8'h80;

    // Input select codes
    localparam logic [3:0] INP_CODE_AIN_FIRST = 4'h3;
    localparam logic [3:0] INP_CODE_AIN_LAST  = 4'h8;
    localparam logic [3:0] INP_CODE_TEMP      = 4'hb;
    localparam logic [3:0] INP_CODE_OPEN      = 4'he;
    localparam logic [3:0] INP_CODE_COMMON_MODE_LEVEL      = 4'hf;

    typedef enum logic [2:0] {ACR_ANALOG, ACR_TEMP, ACR_OPEN, ACR_COMMON_MODE_LEVEL, ACR_RSVD} acr_kind_e;

    typedef struct packed {
        acr_kind_e  kind;
        logic [2:0] ain;
    } acr_inp_s;

    typedef struct packed {
        logic       bypass;
        logic [7:0] gain_factor;
        logic       gain_reserved;
        acr_inp_s   pos;
        acr_inp_s   neg;
    } acr_dec_s;

    localparam acr_dec_s DEC_RESET = '{bypass: 1'b0, gain_factor: GAIN_X1, gain_reserved: 1'b0,
                                       pos: '{kind: ACR_COMMON_MODE_LEVEL, ain: 3'h0}, neg: '{kind: ACR_COMMON_MODE_LEVEL, ain: 3'h0}};

    function automatic acr_inp_s decode_input(input logic [3:0] code);
        acr_inp_s r;
        r.kind = ACR_RSVD;
        r.ain  = 3'h0;
        if (code >= INP_CODE_AIN_FIRST && code <= INP_CODE_AIN_LAST) begin
            r.kind = ACR_ANALOG;
            r.ain  = 3'(code - INP_CODE_AIN_FIRST);
        end else if (code == INP_CODE_TEMP) begin
            r.kind = ACR_TEMP;
        end else if (code == INP_CODE_OPEN) begin
            r.kind = ACR_OPEN;
        end else if (code == INP_CODE_COMMON_MODE_LEVEL) begin
            r.kind = ACR_COMMON_MODE_LEVEL;
        end
        return r;
    endfunction

    // Clamp to the 24-bit two's complement range
    function automatic logic signed [23:0] sat24(input logic signed [27:0] v);
        if (v > 28'sh07fffff) begin
            return 24'sh7fffff;
        end else if (v < 28'shf800000) begin
            return 24'sh800000;
        end
        return v[23:0];
    endfunction

endpackage

// [acr_cfg_if.sv]
// Configuration bundle from the register bank to its decode and scaling logic.
// Assumes one producer (the register bank) and any number of readers.
`timescale 1ns/1ps
interface acr_cfg_if;
    logic [23:0] gain_cal;
    logic [23:0] offset_cal;
    logic [7:0]  amp;
    logic [7:0]  insel;
    modport regs (output gain_cal, offset_cal, amp, insel);
    modport user (input gain_cal, offset_cal, amp, insel);
endinterface

// [acr_input_decode.sv]
// Decodes amplifier and input select settings into registered control outputs.
// Assumes configuration comes from same-clock registers.
`timescale 1ns/1ps
module acr_input_decode (
    // Clock and reset
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    // Configuration
    acr_cfg_if.user    cfg,
    // Decoded controls
    output logic       o_bypass,
    output logic [7:0] o_gain_factor,
    output logic       o_gain_reserved,
    output logic [2:0] o_pos_kind,
    output logic [2:0] o_pos_ain,
    output logic [2:0] o_neg_kind,
    output logic [2:0] o_neg_ain
);
    acr_pkg::acr_dec_s state;
    acr_pkg::acr_dec_s next_state;

    always_comb begin
        next_state        = state;
        next_state.bypass = cfg.amp[acr_pkg::AMP_BYPASS_BIT];
        next_state.gain_reserved = 1'b0;
        case (cfg.amp[2:0])
            acr_pkg::GAIN_CODE_X1:   next_state.gain_factor = acr_pkg::GAIN_X1;
            acr_pkg::GAIN_CODE_X64:  next_state.gain_factor = acr_pkg::GAIN_X64;
            acr_pkg::GAIN_CODE_X128: next_state.gain_factor = acr_pkg::GAIN_X128;
            default: begin
                // Reserved codes fall back to unity and are flagged
                next_state.gain_factor   = acr_pkg::GAIN_X1;
                next_state.gain_reserved = 1'b1;
            end
        endcase
        next_state.pos = acr_pkg::decode_input(cfg.insel[7:acr_pkg::INPUT_POS_LSB]);
        next_state.neg = acr_pkg::decode_input(cfg.insel[3:0]);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= acr_pkg::DEC_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_bypass        = state.bypass;
    assign o_gain_factor   = state.gain_factor;
    assign o_gain_reserved = state.gain_reserved;
    assign o_pos_kind      = state.pos.kind;
    assign o_pos_ain       = state.pos.ain;
    assign o_neg_kind      = state.neg.kind;
    assign o_neg_ain       = state.neg.ain;
endmodule // acr_input_decode

// [acr_scaler.sv]
// Two-stage result correction: offset removal, then full-scale multiply.
// Assumes raw results and calibration words arrive on the same clock.
`timescale 1ns/1ps
module acr_scaler (
    // Clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // Configuration
    acr_cfg_if.user            cfg,
    // Raw conversion
    input  wire logic          i_raw_valid,
    input  wire logic [23:0]   i_raw_data,
    // Corrected result
    output logic               o_result_valid,
    output logic signed [23:0] o_result
);
    typedef struct packed {
        logic               diff_valid;
        logic signed [24:0] diff;
        logic [23:0]        gain;
        logic               res_valid;
        logic signed [23:0] res;
    } acr_scale_s;

    acr_scale_s         state;
    acr_scale_s         next_state;
    logic signed [49:0] product;

    always_comb begin
        next_state = state;
        // Gain word is captured with the sample so a mid-flight write cannot mix two words
        product = state.diff * $signed({1'b0, state.gain});
        next_state.diff_valid = i_raw_valid;
        if (i_raw_valid) begin
            next_state.diff = {i_raw_data[23], i_raw_data} - {cfg.offset_cal[23], cfg.offset_cal};
            next_state.gain = cfg.gain_cal;
        end
        next_state.res_valid = state.diff_valid;
        if (state.diff_valid) begin
            next_state.res = acr_pkg::sat24(product[acr_pkg::GAIN_CAL_SHIFT +: 28]);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_result_valid = state.res_valid;
    assign o_result       = state.res;
endmodule // acr_scaler

// [acr_regs.sv]
// Register bank for gain calibration, reserved bytes, amplifier and input select.
// Assumes a same-clock byte register port and an offset word from the neighbouring bank.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module acr_regs (
    // Clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // Register port
    input  wire logic [7:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic [7:0]         o_rdata,
    // Offset calibration word from neighbouring bank
    input  wire logic [23:0]   i_offset_calibration_word,
    // Raw conversion stream
    input  wire logic          i_raw_valid,
    input  wire logic [23:0]   i_raw_data,
    // Corrected result stream
    output logic               o_result_valid,
    output logic signed [23:0] o_result,
    // Amplifier controls
    output logic               o_bypass,
    output logic [7:0]         o_gain_factor,
    output logic               o_gain_reserved,
    // Input selection
    output logic [2:0]         o_pos_kind,
    output logic [2:0]         o_pos_ain,
    output logic [2:0]         o_neg_kind,
    output logic [2:0]         o_neg_ain
);
    typedef struct packed {
        logic [23:0] gain_calibration_word;
        logic [7:0]  amplifier_config;
        logic [7:0]  input_select;
        logic [7:0]  rdata;
    } acr_regs_s;

    localparam acr_regs_s REGS_RESET = '{gain_calibration_word: acr_pkg::GAIN_CAL_RESET,
                                         amplifier_config: acr_pkg::AMP_CONFIG_RESET,
                                         input_select: acr_pkg::INPUT_SELECT_RESET,
                                         rdata: acr_pkg::READ_ZERO};

    acr_regs_s state;
    acr_regs_s next_state;
    acr_cfg_if cfg ();

    always_comb begin
        next_state = state;
        if (i_wr) begin
            if (i_addr == acr_pkg::ADDR_GAIN_CAL_LO) begin
                next_state.gain_calibration_word[7:0] = i_wdata;
            end else if (i_addr == acr_pkg::ADDR_GAIN_CAL_MID) begin
                next_state.gain_calibration_word[15:8] = i_wdata;
            end else if (i_addr == acr_pkg::ADDR_GAIN_CAL_HI) begin
                next_state.gain_calibration_word[23:16] = i_wdata;
            end else if (i_addr == acr_pkg::ADDR_AMP_CONFIG) begin
                // Reserved bits stored as written; software keeps them zero
                next_state.amplifier_config = i_wdata;
            end else if (i_addr == acr_pkg::ADDR_INPUT_SELECT) begin
                // Reserved codes are not blocked; the decoder flags them
                next_state.input_select = i_wdata;
            end
            // Reserved and unmapped addresses drop the write
        end
        next_state.rdata = acr_pkg::READ_ZERO;
        if (i_rd) begin
            if (i_addr == acr_pkg::ADDR_GAIN_CAL_LO) begin
                next_state.rdata = state.gain_calibration_word[7:0];
            end else if (i_addr == acr_pkg::ADDR_GAIN_CAL_MID) begin
                next_state.rdata = state.gain_calibration_word[15:8];
            end else if (i_addr == acr_pkg::ADDR_GAIN_CAL_HI) begin
                next_state.rdata = state.gain_calibration_word[23:16];
            end else if (i_addr == acr_pkg::ADDR_AMP_CONFIG) begin
                next_state.rdata = state.amplifier_config;
            end else if (i_addr == acr_pkg::ADDR_INPUT_SELECT) begin
                next_state.rdata = state.input_select;
            end else begin
                // 0Dh resets to FFh yet reads zero, so no storage is kept for it
                next_state.rdata = acr_pkg::READ_ZERO;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= REGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;

    assign cfg.gain_cal   = state.gain_calibration_word;
    assign cfg.offset_cal = i_offset_calibration_word;
    assign cfg.amp        = state.amplifier_config;
    assign cfg.insel      = state.input_select;

    acr_scaler u_scaler (
        .i_clock        (i_clock),
        .i_rst          (i_rst),
        .cfg            (cfg.user),
        .i_raw_valid    (i_raw_valid),
        .i_raw_data     (i_raw_data),
        .o_result_valid (o_result_valid),
        .o_result       (o_result)
    );

    acr_input_decode u_decode (
        .i_clock         (i_clock),
        .i_rst           (i_rst),
        .cfg             (cfg.user),
        .o_bypass        (o_bypass),
        .o_gain_factor   (o_gain_factor),
        .o_gain_reserved (o_gain_reserved),
        .o_pos_kind      (o_pos_kind),
        .o_pos_ain       (o_pos_ain),
        .o_neg_kind      (o_neg_kind),
        .o_neg_ain       (o_neg_ain)
    );

    // Checks
    localparam logic [23:0] GAIN_CAL_DOUBLE = 24'h800000;

    logic signed [27:0] chk_diff;
    logic signed [23:0] chk_unity;
    logic signed [23:0] chk_double;
    logic               chk_rsvd_addr;

    assign chk_diff   = {{4{i_raw_data[23]}}, i_raw_data}
                        - {{4{i_offset_calibration_word[23]}}, i_offset_calibration_word};
    assign chk_unity  = acr_pkg::sat24(chk_diff);
    assign chk_double = acr_pkg::sat24(28'(chk_diff <<< 1));
    assign chk_rsvd_addr = (i_addr >= acr_pkg::ADDR_RSVD_ONES) && (i_addr <= acr_pkg::ADDR_RSVD_ZERO_B);

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence s_lo_write;
        i_wr && i_addr == acr_pkg::ADDR_GAIN_CAL_LO;
    endsequence

    sequence s_lo_read_next;
        ##1 (i_rd && i_addr == acr_pkg::ADDR_GAIN_CAL_LO);
    endsequence

    sequence s_unity_sample;
        i_raw_valid && state.gain_calibration_word == acr_pkg::GAIN_CAL_RESET;
    endsequence

    sequence s_double_sample;
        i_raw_valid && state.gain_calibration_word == GAIN_CAL_DOUBLE;
    endsequence

    a_cal_reset_word: assert property (
        $fell(i_rst) |-> state.gain_calibration_word == acr_pkg::GAIN_CAL_RESET)
        else $error("Gain calibration word not at reset value");

    a_cal_readback_lo: assert property (
        s_lo_write ##0 s_lo_read_next |=> o_rdata == $past(i_wdata, 2))
        else $error("Gain calibration low byte did not read back");

    a_scale_unity: assert property (
        s_unity_sample |-> ##2 (o_result_valid && o_result == $past(chk_unity, 2)))
        else $error("Unity gain word did not pass offset-corrected data");

    a_offset_first_double: assert property (
        s_double_sample |-> ##2 (o_result_valid && o_result == $past(chk_double, 2)))
        else $error("Offset not removed before gain multiply");

    a_rsvd_read_zero: assert property (
        i_rd && chk_rsvd_addr |=> o_rdata == acr_pkg::READ_ZERO)
        else $error("Reserved byte read not zero");

    a_rsvd_write_ignored: assert property (
        i_wr && chk_rsvd_addr |=> $stable(state.gain_calibration_word) && $stable(state.amplifier_config)
                                  && $stable(state.input_select))
        else $error("Reserved byte write changed a register");

    a_bypass_follows_write: assert property (
        i_wr && i_addr == acr_pkg::ADDR_AMP_CONFIG |=> ##1 o_bypass == $past(i_wdata[7], 2))
        else $error("Bypass output did not follow amplifier bit 7");

    a_gain_x64_map: assert property (
        i_wr && i_addr == acr_pkg::ADDR_AMP_CONFIG && i_wdata[2:0] == acr_pkg::GAIN_CODE_X64
        |=> ##1 (o_gain_factor == acr_pkg::GAIN_X64 && !o_gain_reserved))
        else $error("Gain code 110 did not select 64");

    a_pos_analog_map: assert property (
        i_wr && i_addr == acr_pkg::ADDR_INPUT_SELECT && i_wdata[7:4] >= acr_pkg::INP_CODE_AIN_FIRST
        && i_wdata[7:4] <= acr_pkg::INP_CODE_AIN_LAST
        |=> ##1 (o_pos_kind == acr_pkg::ACR_ANALOG && o_pos_ain == 3'($past(i_wdata[7:4], 2) - 4'h3)))
        else $error("Positive analog input code mis-decoded");

    a_neg_temp_map: assert property (
        i_wr && i_addr == acr_pkg::ADDR_INPUT_SELECT && i_wdata[3:0] == acr_pkg::INP_CODE_TEMP
        |=> ##1 o_neg_kind == acr_pkg::ACR_TEMP)
        else $error("Negative temperature code mis-decoded");

    a_common_mode_level_after_reset: assert property (
        $fell(i_rst) |-> (o_pos_kind == acr_pkg::ACR_COMMON_MODE_LEVEL && o_neg_kind == acr_pkg::ACR_COMMON_MODE_LEVEL
                          && state.input_select == acr_pkg::INPUT_SELECT_RESET))
        else $error("Inputs not at common-mode level after reset");
endmodule // acr_regs

// [tb_acr_regs.sv]
// Self-checking bench for the gain calibration, amplifier and input select bank.
// Assumes acr_pkg, acr_cfg_if and all design modules are compiled first.
`timescale 1ns/1ps
module tb_acr_regs;
    logic               i_clock = 1'b0;
    logic               i_rst = 1'b1;
    logic [7:0]         i_addr = 8'h00;
    logic [7:0]         i_wdata = 8'h00;
    logic               i_wr = 1'b0;
    logic               i_rd = 1'b0;
    logic [7:0]         o_rdata;
    logic [23:0]        ofs = 24'h000000;
    logic               i_raw_valid = 1'b0;
    logic [23:0]        i_raw_data = 24'h000000;
    logic               o_result_valid;
    logic signed [23:0] o_result;
    logic               o_bypass;
    logic [7:0]         o_gain_factor;
    logic               o_gain_reserved;
    logic [2:0]         o_pos_kind;
    logic [2:0]         o_pos_ain;
    logic [2:0]         o_neg_kind;
    logic [2:0]         o_neg_ain;
    int                 num_errors = 0;
    int                 num_checks = 0;
    int                 cyc = 0;
    logic [31:0]        seed = 32'h9d9123ba;
    logic [7:0]         mdl [0:255];
    logic [23:0]        exp_q [$];
    int                 at_q [$];

    always #50 i_clock = ~i_clock;

    acr_regs i_acr_regs (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_offset_calibration_word(ofs),
        .i_raw_valid(i_raw_valid), .i_raw_data(i_raw_data), .o_result_valid(o_result_valid),
        .o_result(o_result), .o_bypass(o_bypass), .o_gain_factor(o_gain_factor),
        .o_gain_reserved(o_gain_reserved), .o_pos_kind(o_pos_kind), .o_pos_ain(o_pos_ain),
        .o_neg_kind(o_neg_kind), .o_neg_ain(o_neg_ain));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Writable places keep their byte; all others read zero, 0Dh included
    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        if (a inside {8'h0a, 8'h0b, 8'h0c, 8'h10, 8'h11}) begin
            return mdl[a];
        end
        return 8'h00;
    endfunction

    function automatic logic [5:0] inp_exp(input logic [3:0] c);
        if (c >= 4'h3 && c <= 4'h8) begin
            return {3'h0, 3'(c - 4'h3)};
        end
        case (c)
            4'hb: return 6'h08;
            4'he: return 6'h10;
            4'hf: return 6'h18;
            default: return 6'h20;
        endcase
    endfunction

    // Legal input select codes only; software keeps to them
    function automatic logic [3:0] lc(input int n);
        case (n % 9)
            6: return 4'hb;
            7: return 4'he;
            8: return 4'hf;
            default: return 4'(n % 9 + 3);
        endcase
    endfunction

    function automatic logic [21:0] dec_exp(input logic [7:0] amp, input logic [7:0] sel);
        logic [7:0] f;
        logic       r;
        f = (amp[2:0] == 3'h6) ? 8'h40 : (amp[2:0] == 3'h7) ? 8'h80 : 8'h01;
        r = !(amp[2:0] inside {3'h0, 3'h6, 3'h7});
        return {amp[7], f, r, inp_exp(sel[7:4]), inp_exp(sel[3:0])};
    endfunction

    // Wide integers keep the product exact; floor shift then clamp
    function automatic logic [23:0] res_exp(input logic [23:0] raw, input logic [23:0] o);
        longint d;
        longint g;
        d = longint'($signed(raw)) - longint'($signed(o));
        g = longint'({mdl[8'h0c], mdl[8'h0b], mdl[8'h0a]});
        d = (d * g) >>> 22;
        if (d > 64'sh7fffff) d = 64'sh7fffff;
        if (d < -64'sh800000) d = -64'sh800000;
        return d[23:0];
    endfunction

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        report({24'h0, got}, {24'h0, exp});
    endtask

    task automatic chk_dec();
        report({10'h0, o_bypass, o_gain_factor, o_gain_reserved, o_pos_kind, o_pos_ain,
                o_neg_kind, o_neg_ain}, {10'h0, dec_exp(mdl[8'h10], mdl[8'h11])});
    endtask

    task automatic chk_res(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        if (a inside {8'h0a, 8'h0b, 8'h0c, 8'h10, 8'h11}) mdl[a] = d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk_rd(o_rdata, rd_exp(a));
        @(posedge i_clock);
    endtask

    // Back-to-back samples; the first two push the clamp both ways when the gain word is at unity or above
    task automatic stream(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            r = xs();
            i_raw_valid <= 1'b1;
            i_raw_data <= (i == 0) ? 24'h7fffff : (i == 1) ? 24'h800000 : r[23:0];
            ofs <= (i == 0) ? 24'h800000 : (i == 1) ? 24'h7fffff : {{4{r[31]}}, r[31:12]};
            @(posedge i_clock);
        end
        i_raw_valid <= 1'b0;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge i_clock);
        if (exp_q.size() != 0) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Result monitor: each sample answers exactly two cycles after it is taken
    always @(negedge i_clock) begin
        cyc = cyc + 1;
        if (!i_rst && o_result_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk_res(32'h1, 32'h0);
            end else begin
                chk_res({8'h0, o_result}, {8'h0, exp_q.pop_front()});
                chk_res(cyc, at_q.pop_front());
            end
        end
        if (!i_rst && i_raw_valid === 1'b1) begin
            exp_q.push_back(res_exp(i_raw_data, ofs));
            at_q.push_back(cyc + 2);
        end
    end

    initial begin
        #(100 * 50000);
        num_errors++;
        close_out();
    end

    initial begin
        logic [31:0] r;
        for (int a = 0; a < 256; a++) mdl[a] = 8'h00;
        mdl[8'h0c] = 8'h40;
        mdl[8'h11] = 8'hff;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        chk_dec();
        @(posedge i_clock);
        for (int a = 8'h0a; a <= 8'h11; a++) bus_rd(8'(a));
        stream(12);
        for (int a = 8'h0a; a <= 8'h12; a++) begin
            r = xs();
            // Amplifier reserved bits and input select codes kept legal
            bus_wr((a == 8'h12) ? 8'h20 : 8'(a), (a == 8'h11) ? {lc(r[3:0]), lc(r[7:4])}
                   : (a == 8'h10) ? (r[7:0] & 8'h87) : r[7:0]);
        end
        for (int a = 8'h0a; a <= 8'h12; a++) bus_rd((a == 8'h12) ? 8'h20 : 8'(a));
        for (int g = 0; g < 16; g++) begin
            bus_wr(8'h10, {g[3], 4'h0, g[2:0]});
            @(negedge i_clock);
            chk_dec();
            @(posedge i_clock);
        end
        for (int c = 0; c < 16; c++) begin
            bus_wr(8'h11, {lc(c), lc(c + 5)});
            @(negedge i_clock);
            chk_dec();
            @(posedge i_clock);
            bus_rd(8'h11);
        end
        for (int p = 0; p < 4; p++) begin
            r = (p == 0) ? xs() : (p == 1) ? 32'hffffff : (p == 2) ? 32'h000001 : 32'h800000;
            // Low byte written then read with no gap
            i_wr <= 1'b1;
            i_addr <= 8'h0a;
            i_wdata <= r[7:0];
            mdl[8'h0a] = r[7:0];
            @(posedge i_clock);
            i_wr <= 1'b0;
            bus_rd(8'h0a);
            bus_wr(8'h0b, r[15:8]);
            bus_wr(8'h0c, r[23:16]);
            bus_rd(8'h0b);
            stream(16);
        end
        close_out();
    end
endmodule // tb_acr_regs
